// file: hw/rsso_pkg.sv
// Contract
// RULE1: rotate-left puts old bit 31 in carry
// RULE2: rotate-right: old carry to 31, bit0 to carry
// RULE3: prefix never alters rotate-right
// RULE4: window opening decrements the window pointer
// RULE5: opening at window floor raises trap 1
// RULE6: new stack pointer is frame pointer minus size*4
// RULE7: new frame pointer aliases caller stack pointer
// RULE8: window opening carries 8-bit size in low byte
// RULE9: halfword widen copies bit 15 upward
// RULE10: byte widen copies bit 7 upward
// RULE11: bit-clear skip when selected bit is zero
// RULE12: bit-set skip when selected bit is one
// RULE13: bit index is 5-bit unsigned field
// RULE14: skip steps pc 6 over prefix, else 4
// RULE15: nonzero skip when operand is not zero
// RULE16: zero skip when operand equals zero
// RULE17: condition skip decodes fourteen flag tests
// RULE18: plain store uses address bits 31 to 2
// RULE19: prefixed store adds sign-extended prefix times 4
// RULE20: prefix op loads 11-bit prefix value
// RULE21: every other instruction clears the prefix value
// RULE22: skipped instructions have no side effects
// RULE23: operand register index is bits 4 to 0
// RULE24: these operations leave flags unchanged
package rsso_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NWIN   = 4;
  localparam int unsigned NPHYS  = 80;

  localparam logic [7:0] OFS_EXEC    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_WINDOW  = 8'h08;
  localparam logic [7:0] OFS_PC      = 8'h0c;
  localparam logic [7:0] OFS_REGSEL  = 8'h10;
  localparam logic [7:0] OFS_REGDATA = 8'h14;
  localparam logic [7:0] OFS_ST_ADDR = 8'h18;
  localparam logic [7:0] OFS_ST_DATA = 8'h1c;

  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_V = 2;
  localparam int unsigned FLG_N = 3;
  localparam int unsigned STAT_FLAG_LSB = 0;
  localparam int unsigned STAT_SKIP     = 8;
  localparam int unsigned STAT_TRAP     = 9;
  localparam int unsigned STAT_K_LSB    = 16;
  localparam int unsigned WIN_CWP_LSB   = 0;
  localparam int unsigned WIN_FLOOR_LSB = 8;

  localparam logic [1:0]  RST_CWP   = 2'h3;
  localparam logic [1:0]  RST_FLOOR = 2'h0;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  localparam logic [31:0] RST_PC    = 32'h0;

  localparam logic [10:0] OP_RLC    = 11'h3e5;
  localparam logic [10:0] OP_RRC    = 11'h3e6;
  localparam logic [10:0] OP_HALFWORD_SIGN_WIDEN = 11'h3e4;
  localparam logic [10:0] OP_BYTE_SIGN_WIDEN  = 11'h3e3;
  localparam logic [10:0] OP_SKPNZ  = 11'h3fa;
  localparam logic [10:0] OP_SKPZ   = 11'h3f6;
  localparam logic [11:0] OP_SKPC   = 12'h7ee;
  localparam logic [7:0]  OP_SAVE   = 8'h78;
  localparam logic [5:0]  OP_SKPB0  = 6'h14;
  localparam logic [5:0]  OP_SKPB1  = 6'h15;
  localparam logic [5:0]  OP_STORE  = 6'h1a;
  localparam logic [4:0]  OP_PFX    = 5'h13;

  localparam logic [4:0] SP_REG = 5'h0e;
  localparam logic [5:0] TRAP_UNDERFLOW = 6'h01;
  localparam logic [2:0] STEP_INSN     = 3'h2;
  localparam logic [2:0] STEP_SKIP     = 3'h4;
  localparam logic [2:0] STEP_SKIP_PFX = 3'h6;

  // windows slide by 16, so a callee's in-registers alias the caller's outs
  function automatic logic [6:0] phys_idx(input logic [1:0] window_pointer,
                                          input logic [4:0] r);
    if (r < 5'h08) begin
      return {2'h0, r};
    end
    return {1'b0, window_pointer, 4'h0} + {2'h0, r};
  endfunction
endpackage

// file: hw/rsso_exec_if.sv
`timescale 1ns/1ps
interface rsso_exec_if;
  logic [15:0] insn;
  logic [15:0] next_insn;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [3:0]  flags;
  logic [10:0] k;
  logic [31:0] result;
  logic        res_we;
  logic        carry;
  logic        carry_we;
  logic        skip;
  logic        is_pfx;
  logic        is_save;
  logic        st_en;
  logic [29:0] st_word;

  modport dec (input insn, next_insn, opa, opb, flags, k,
               output result, res_we, carry, carry_we, skip, is_pfx,
               is_save, st_en, st_word);
  modport core (output insn, next_insn, opa, opb, flags, k,
                input result, res_we, carry, carry_we, skip, is_pfx,
                is_save, st_en, st_word);
endinterface

// file: hw/rsso_decode.sv
`timescale 1ns/1ps
module rsso_decode (
  rsso_exec_if.dec x
);
  import rsso_pkg::*;

  function automatic logic cond_true(input logic [3:0] cc,
                                     input logic [3:0] f);
    logic lt;
    lt = f[FLG_N] ^ f[FLG_V];
    case (cc)
      4'h0: return f[FLG_C];
      4'h1: return ~f[FLG_C];
      4'h2: return f[FLG_Z];
      4'h3: return ~f[FLG_Z];
      4'h4: return f[FLG_N];
      4'h5: return ~f[FLG_N];
      4'h6: return ~lt;
      4'h7: return lt;
      4'h8: return f[FLG_Z] | lt;
      4'h9: return ~(f[FLG_Z] | lt);
      4'ha: return f[FLG_V];
      4'hb: return ~f[FLG_V];
      4'hc: return f[FLG_C] | f[FLG_Z];
      4'hd: return ~(f[FLG_C] | f[FLG_Z]);
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    x.result   = x.opa;
    x.res_we   = 1'b0;
    x.carry    = x.flags[FLG_C];
    x.carry_we = 1'b0;
    x.skip     = 1'b0;
    x.is_pfx   = 1'b0;
    x.is_save  = 1'b0;
    x.st_en    = 1'b0;
    // RULE18 word address drops two bits
    x.st_word  = x.opb[31:2];
    if (x.insn[15:11] == OP_PFX) begin
      x.is_pfx = 1'b1;
    // RULE8 size byte below fixed opcode
    end else if (x.insn[15:8] == OP_SAVE) begin
      x.is_save = 1'b1;
    // RULE11 RULE13 five-bit index clear test
    end else if (x.insn[15:10] == OP_SKPB0) begin
      x.skip = ~x.opa[x.insn[9:5]];
    // RULE12 five-bit index set test
    end else if (x.insn[15:10] == OP_SKPB1) begin
      x.skip = x.opa[x.insn[9:5]];
    end else if (x.insn[15:10] == OP_STORE) begin
      x.st_en = 1'b1;
      // RULE19 signed word offset from prefix
      x.st_word = x.opb[31:2] + {{19{x.k[10]}}, x.k};
    // RULE17 flag condition table
    end else if (x.insn[15:4] == OP_SKPC) begin
      x.skip = cond_true(x.insn[3:0], x.flags);
    end else begin
      case (x.insn[15:5])
        // RULE1 old msb into carry
        OP_RLC: begin
          x.result   = {x.opa[30:0], x.flags[FLG_C]};
          x.carry    = x.opa[31];
          x.res_we   = 1'b1;
          x.carry_we = 1'b1;
        end
        // RULE2 RULE3 rotate right ignores prefix
        OP_RRC: begin
          x.result   = {x.flags[FLG_C], x.opa[31:1]};
          x.carry    = x.opa[0];
          x.res_we   = 1'b1;
          x.carry_we = 1'b1;
        end
        // RULE9 copy bit 15 upward
        OP_HALFWORD_SIGN_WIDEN: begin
          x.result = {{16{x.opa[15]}}, x.opa[15:0]};
          x.res_we = 1'b1;
        end
        // RULE10 copy bit 7 upward
        OP_BYTE_SIGN_WIDEN: begin
          x.result = {{24{x.opa[7]}}, x.opa[7:0]};
          x.res_we = 1'b1;
        end
        // RULE15 whole register nonzero
        OP_SKPNZ: x.skip = |x.opa;
        // RULE16 whole register zero
        OP_SKPZ: x.skip = ~|x.opa;
        default: x.skip = 1'b0;
      endcase
    end
  end
endmodule

// file: hw/rsso_top.sv
`timescale 1ns/1ps
module rsso_top (
  input  wire logic                        i_mclk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_hsel,
  input  wire logic [rsso_pkg::DATA_W-1:0] i_haddr,
  input  wire logic [1:0]                  i_htrans,
  input  wire logic                        i_hwrite,
  input  wire logic [2:0]                  i_hsize,
  input  wire logic [rsso_pkg::DATA_W-1:0] i_hwdata,
  input  wire logic                        i_hready,
  output logic                             o_hreadyout,
  output logic                             o_hresp,
  output logic      [rsso_pkg::DATA_W-1:0] o_hrdata,
  output logic                             o_mem_we,
  output logic      [29:0]                 o_mem_addr,
  output logic      [rsso_pkg::DATA_W-1:0] o_mem_wdata,
  output logic                             o_trap,
  output logic      [5:0]                  o_trap_num
);
  import rsso_pkg::*;

  typedef enum logic [1:0] {SK_RUN, SK_DROP1, SK_DROP2} rsso_skip_e;

  rsso_exec_if x ();

  rsso_decode u_decode (
    .x (x.dec)
  );

  logic [31:0] rf [NPHYS];
  logic [3:0]  flags;
  logic [1:0]  window_pointer;
  logic [1:0]  floor_w;
  logic [31:0] pc;
  logic [10:0] k;
  logic [4:0]  regsel;
  logic [31:0] last_exec;
  logic        trap_flag;
  rsso_skip_e  skip_st;
  rsso_skip_e  next_skip_st;

  logic        dp_wr;
  logic        rd_wait;
  logic [7:0]  dp_addr;
  logic        acc;
  logic        exec_fire;
  logic        run;
  logic        drop;
  logic        next_pfx;
  logic        save_ok;
  logic        save_trap;
  logic [31:0] sp_new;
  logic [2:0]  step;
  logic [31:0] status_word;

  // bus side: address phase is taken when hready is high
  assign acc         = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = ~rd_wait;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (i_hready) begin
      dp_wr   <= acc & i_hwrite;
      dp_addr <= i_haddr[7:0];
    end
  end

  // one wait state on reads lets a write just before land first
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= acc & ~i_hwrite;
    end
  end

  assign exec_fire = dp_wr && dp_addr == OFS_EXEC;
  assign run       = exec_fire && skip_st == SK_RUN;
  assign drop      = exec_fire && skip_st != SK_RUN;
  assign next_pfx  = x.next_insn[15:11] == OP_PFX;

  // RULE23 operand index in low five bits
  assign x.insn      = i_hwdata[15:0];
  assign x.next_insn = i_hwdata[31:16];
  assign x.opa       = rf[phys_idx(window_pointer, x.insn[4:0])];
  assign x.opb       = rf[phys_idx(window_pointer, x.insn[9:5])];
  assign x.flags     = flags;
  assign x.k         = k;

  // RULE5 floor check before moving
  assign save_ok   = run && x.is_save && window_pointer != floor_w;
  assign save_trap = run && x.is_save && window_pointer == floor_w;
  // RULE6 frame size scaled by four
  assign sp_new = rf[phys_idx(window_pointer, SP_REG)]
                  - {22'h0, x.insn[7:0], 2'h0};

  // RULE14 longer step over a prefix
  always_comb begin
    step = STEP_INSN;
    if (x.skip) begin
      step = next_pfx ? STEP_SKIP_PFX : STEP_SKIP;
    end
  end

  function automatic logic wr_regdata();
    return dp_wr && dp_addr == OFS_REGDATA;
  endfunction

  // register file, indexed through the window mapping
  always_ff @(posedge i_mclk) begin
    if (wr_regdata()) begin
      rf[phys_idx(window_pointer, regsel)] <= i_hwdata;
    end else if (run && x.res_we) begin
      rf[phys_idx(window_pointer, x.insn[4:0])] <= x.result;
    // RULE7 new frame pointer aliases old sp
    end else if (save_ok) begin
      rf[phys_idx(window_pointer - 2'h1, SP_REG)] <= sp_new;
    end
  end

  // RULE24 only rotates touch the carry
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flags <= RST_FLAGS;
    end else if (dp_wr && dp_addr == OFS_STATUS) begin
      flags <= i_hwdata[STAT_FLAG_LSB +: 4];
    end else if (run && x.carry_we) begin
      flags[FLG_C] <= x.carry;
    end
  end

  // RULE4 one window down
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      window_pointer     <= RST_CWP;
      floor_w <= RST_FLOOR;
    end else if (dp_wr && dp_addr == OFS_WINDOW) begin
      window_pointer     <= i_hwdata[WIN_CWP_LSB +: 2];
      floor_w <= i_hwdata[WIN_FLOOR_LSB +: 2];
    end else if (save_ok) begin
      window_pointer <= window_pointer - 2'h1;
    end
  end

  // RULE20 RULE21 load or clear the prefix
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      k <= 11'h000;
    end else if (run) begin
      k <= x.is_pfx ? x.insn[10:0] : 11'h000;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pc <= RST_PC;
    end else if (dp_wr && dp_addr == OFS_PC) begin
      pc <= i_hwdata;
    end else if (run) begin
      pc <= pc + {29'h0, step};
    end
  end

  // RULE22 dropped words change nothing
  always_comb begin
    next_skip_st = skip_st;
    case (skip_st)
      SK_RUN: begin
        if (run && x.skip) begin
          next_skip_st = next_pfx ? SK_DROP2 : SK_DROP1;
        end
      end
      SK_DROP2: if (drop) next_skip_st = SK_DROP1;
      SK_DROP1: if (drop) next_skip_st = SK_RUN;
      default: next_skip_st = SK_RUN;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      skip_st <= SK_RUN;
    end else begin
      skip_st <= next_skip_st;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      regsel    <= 5'h00;
      last_exec <= 32'h0;
    end else begin
      if (dp_wr && dp_addr == OFS_REGSEL) begin
        regsel <= i_hwdata[4:0];
      end
      if (exec_fire) begin
        last_exec <= i_hwdata;
      end
    end
  end

  // store port: one-cycle write strobe, address and data held after
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 30'h0;
      o_mem_wdata <= 32'h0;
    end else begin
      o_mem_we <= run && x.st_en;
      if (run && x.st_en) begin
        o_mem_addr  <= x.st_word;
        o_mem_wdata <= x.opa;
      end
    end
  end

  // RULE5 trap pulse, sticky copy; a new trap beats a clear
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_trap     <= 1'b0;
      o_trap_num <= 6'h00;
      trap_flag  <= 1'b0;
    end else begin
      o_trap <= save_trap;
      if (save_trap) begin
        o_trap_num <= TRAP_UNDERFLOW;
        trap_flag  <= 1'b1;
      end else if (dp_wr && dp_addr == OFS_STATUS
                   && i_hwdata[STAT_TRAP]) begin
        trap_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[STAT_FLAG_LSB +: 4] = flags;
    status_word[STAT_SKIP]          = skip_st != SK_RUN;
    status_word[STAT_TRAP]          = trap_flag;
    status_word[STAT_K_LSB +: 11]   = k;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0;
    end else if (rd_wait) begin
      case (dp_addr)
        OFS_EXEC:    o_hrdata <= last_exec;
        OFS_STATUS:  o_hrdata <= status_word;
        OFS_WINDOW:  o_hrdata <= {22'h0, floor_w, 6'h0, window_pointer};
        OFS_PC:      o_hrdata <= pc;
        OFS_REGSEL:  o_hrdata <= {27'h0, regsel};
        OFS_REGDATA: o_hrdata <= rf[phys_idx(window_pointer, regsel)];
        OFS_ST_ADDR: o_hrdata <= {o_mem_addr, 2'h0};
        OFS_ST_DATA: o_hrdata <= o_mem_wdata;
        default:     o_hrdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_rlc;
    run && x.insn[15:5] == OP_RLC;
  endsequence
  sequence s_rrc;
    run && x.insn[15:5] == OP_RRC;
  endsequence
  sequence s_skip_pfx;
    run && x.skip && next_pfx;
  endsequence
  sequence s_trap_pulse;
    o_trap && o_trap_num == 6'h01 ##1 !o_trap;
  endsequence

  chk_rlc_carry_msb: assert property ( // RULE1
    s_rlc |=> flags[FLG_C] == $past(x.opa[31]))
    else $error("carry not loaded from old bit 31");
  chk_rrc_carry_lsb: assert property ( // RULE2
    s_rrc |=> flags[FLG_C] == $past(x.opa[0]))
    else $error("carry not loaded from old bit 0");
  chk_save_window_dec: assert property ( // RULE4
    save_ok |=> window_pointer == $past(window_pointer) - 2'h1)
    else $error("window pointer not decremented");
  chk_save_trap_one: assert property ( // RULE5
    save_trap |=> s_trap_pulse and $stable(window_pointer))
    else $error("underflow trap missing or window moved");
  chk_frame_sp_val: assert property ( // RULE6
    save_ok |=> rf[phys_idx(window_pointer, SP_REG)] == $past(sp_new))
    else $error("new stack pointer wrong");
  chk_skip_pfx_step: assert property ( // RULE14
    s_skip_pfx |=> pc == $past(pc) + 32'h6 && skip_st == SK_DROP2
    ##1 skip_st != SK_RUN)
    else $error("skip over prefix stepped wrong");
  chk_prefix_cleared: assert property ( // RULE21
    run && !x.is_pfx |=> k == 11'h000)
    else $error("prefix value not cleared");
  chk_prefix_loaded: assert property ( // RULE20
    run && x.is_pfx |=> k == $past(x.insn[10:0]))
    else $error("prefix value not loaded");
  chk_drop_quiet: assert property ( // RULE22
    drop |=> $stable(pc) && $stable(k) && !o_mem_we && !o_trap)
    else $error("skipped instruction had an effect");
  chk_store_addr: assert property ( // RULE19
    run && x.st_en |=> o_mem_we && o_mem_addr ==
      $past(x.opb[31:2] + {{19{x.k[10]}}, x.k}) ##1 !o_mem_we)
    else $error("store address wrong");
  chk_flags_kept: assert property ( // RULE24
    run && !x.carry_we |=> $stable(flags))
    else $error("flags changed by a flag-neutral op");
endmodule

// file: dv/rsso_mem_model.sv
`timescale 1ns/1ps
module rsso_mem_model (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic        i_we,
  input wire logic [29:0] i_addr,
  input wire logic [31:0] i_wdata
);
  logic [31:0] mem [logic [29:0]];
  logic [29:0] last_addr;
  logic [31:0] last_data;
  int          n_wr;

  initial n_wr = 0;

  // word-wide sink: no byte lanes, so every pulse lands one whole word
  always @(posedge i_mclk) begin
    if (!i_sys_rst && i_we === 1'b1) begin
      mem[i_addr] = i_wdata;
      last_addr = i_addr;
      last_data = i_wdata;
      n_wr = n_wr + 1;
    end
  end
endmodule

// file: dv/test_rotate_skip_store_ops.sv
`timescale 1ns/1ps
module test_rotate_skip_store_ops;
  import rsso_pkg::*;
  logic        clk, rst, hsel, hwrite, hrdy, hresp, mwe, trap;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, mdata;
  logic [29:0] maddr;
  logic [5:0]  tnum;
  int          n_fail, checked, n_trap;

  rsso_top dut (
    .i_mclk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_hrdata(hrdata), .o_mem_we(mwe),
    .o_mem_addr(maddr), .o_mem_wdata(mdata), .o_trap(trap),
    .o_trap_num(tnum)
  );
  rsso_mem_model mem (
    .i_mclk(clk), .i_sys_rst(rst), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!rst && trap === 1'b1) begin
      n_trap <= n_trap + 1;
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask

  task setr(input logic [4:0] r, input logic [31:0] v);
    wr(OFS_REGSEL, {27'h0, r});
    wr(OFS_REGDATA, v);
  endtask

  task getr(input logic [4:0] r, output logic [31:0] v);
    wr(OFS_REGSEL, {27'h0, r});
    rd(OFS_REGDATA, v);
  endtask

  task ex(input logic [15:0] i, input logic [15:0] n);
    wr(OFS_EXEC, {n, i});
  endtask

  function automatic logic cond(input logic [3:0] c, input logic [3:0] f);
    logic cy, z, x;
    logic [15:0] t;
    cy = f[FLG_C];
    z = f[FLG_Z];
    x = f[FLG_N] ^ f[FLG_V];
    t = {2'b00, !(cy | z), cy | z, !f[FLG_V], f[FLG_V], !(z | x), z | x,
         x, !x, !f[FLG_N], f[FLG_N], !z, z, !cy, cy};
    return t[c];
  endfunction

  // r1 holds 0x80 so a dropped byte widen would show at once
  task skip_case(input logic [15:0] i, input logic t, input logic pf);
    logic [31:0] p, q, e;
    p = $urandom & 32'hfffe;
    e = p + (t ? (pf ? 6 : 4) : 2);
    setr(5'h01, 32'h80);
    wr(OFS_PC, p);
    ex(i, pf ? {OP_PFX, 11'h7ff} : {OP_BYTE_SIGN_WIDEN, 5'h01});
    rd(OFS_STATUS, q);
    chk("skip flag", {31'h0, t}, {31'h0, q[STAT_SKIP]});
    rd(OFS_PC, q);
    chk("skip pc", e, q); // step size
    if (t && pf) ex({OP_PFX, 11'h7ff}, 16'h0);
    if (t) ex({OP_BYTE_SIGN_WIDEN, 5'h01}, 16'h0);
    getr(5'h01, q);
    chk("dropped op", 32'h80, q); // no write
    rd(OFS_PC, q);
    chk("dropped pc", e, q); // pc kept
    rd(OFS_STATUS, q);
    chk("dropped pfx", 32'h0, {21'h0, q[STAT_K_LSB +: 11]}); // kept
  endtask

  initial begin
    logic [31:0] q, v, ev, sp;
    logic [29:0] w;
    logic [4:0]  ra, b;
    logic [3:0]  f, ef;
    logic [10:0] pk;
    logic [7:0]  sz;
    logic        t;
    int          k, r, nt, n0;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_fail = 0;
    checked = 0;
    n_trap = 0;
    r = $urandom(10559);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h20, q);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    rd(OFS_WINDOW, q);
    chk("window rst", {22'h0, RST_FLOOR, 6'h0, RST_CWP}, q);
    for (k = 0; k < 4; k++) begin
      ra = 5'($urandom);
      v = $urandom;
      f = 4'($urandom);
      ef = f;
      setr(ra, v);
      wr(OFS_STATUS, {28'h0, f});
      if (k[0]) begin
        ex({OP_PFX, 11'h5a5}, 16'h0);
        rd(OFS_STATUS, q);
        chk("prefix", 32'h5a5, {21'h0, q[STAT_K_LSB +: 11]}); // load
        ex({OP_RRC, ra}, 16'h0);
        ev = {f[FLG_C], v[31:1]};
        ef[FLG_C] = v[0];
      end else begin
        ex({OP_RLC, ra}, 16'h0);
        ev = {v[30:0], f[FLG_C]};
        ef[FLG_C] = v[31];
      end
      getr(ra, q);
      chk("rotate", ev, q); // operand
      rd(OFS_STATUS, q);
      chk("rot flags", {28'h0, ef}, {28'h0, q[3:0]}); // carry
      chk("pfx clear", 32'h0, {21'h0, q[STAT_K_LSB +: 11]}); // clear
    end
    for (k = 0; k < 4; k++) begin
      ra = 5'($urandom);
      v = $urandom;
      v[7] = k[1];
      v[15] = k[1];
      f = 4'($urandom);
      setr(ra, v);
      wr(OFS_STATUS, {28'h0, f});
      ex({k[0] ? OP_BYTE_SIGN_WIDEN : OP_HALFWORD_SIGN_WIDEN, ra}, 16'h0);
      ev = k[0] ? {{24{v[7]}}, v[7:0]} : {{16{v[15]}}, v[15:0]};
      getr(ra, q);
      chk("widen", ev, q); // widen
      rd(OFS_STATUS, q);
      chk("widen flags", {28'h0, f}, {28'h0, q[3:0]}); // flags
    end
    for (k = 0; k < 8; k++) begin
      ra = 5'(2 + $urandom % 30);
      b = (k < 2) ? 5'(k * 31) : 5'($urandom);
      v = $urandom;
      t = k[0] ? v[b] : !v[b];
      setr(ra, v);
      skip_case({k[0] ? OP_SKPB1 : OP_SKPB0, b, ra}, t, k[2]);
    end
    for (k = 0; k < 4; k++) begin
      ra = 5'(2 + $urandom % 30);
      v = k[1] ? ($urandom | 32'h1) : 32'h0;
      setr(ra, v);
      skip_case({k[0] ? OP_SKPNZ : OP_SKPZ, ra}, k[0] == k[1], k[0]);
    end
    for (k = 0; k < 16; k++) begin
      f = 4'($urandom);
      wr(OFS_STATUS, {28'h0, f});
      skip_case({OP_SKPC, 4'(k)}, cond(4'(k), f), k[1]); // codes
      rd(OFS_STATUS, q);
      chk("skip flags", {28'h0, f}, {28'h0, q[3:0]}); // flags
    end
    for (k = 0; k < 4; k++) begin
      b = 5'($urandom);
      ra = b ^ 5'h1f;
      v = $urandom;
      ev = $urandom;
      pk = {k[1], 10'($urandom)};
      setr(b, ev);
      setr(ra, v);
      if (k[0]) ex({OP_PFX, pk}, 16'h0);
      n0 = mem.n_wr;
      ex({OP_STORE, b, ra}, 16'h0);
      rd(OFS_ST_ADDR, q);
      w = ev[31:2] + (k[0] ? {{19{pk[10]}}, pk} : 30'h0);
      chk("st addr reg", {w, 2'h0}, q); // readback
      rd(OFS_ST_DATA, q);
      chk("st data reg", v, q); // readback
      chk("store count", 32'(n0 + 1), 32'(mem.n_wr));
      chk("store addr", {2'h0, w}, {2'h0, mem.last_addr});
      chk("store data", v, mem.last_data); // data
    end
    wr(OFS_WINDOW, {30'h0, 2'h3});
    setr(5'h0e, $urandom);
    for (k = 0; k < 4; k++) begin
      getr(5'h0e, sp);
      sz = (k == 0) ? 8'hff : 8'($urandom);
      nt = n_trap;
      ex({OP_SAVE, sz}, 16'h0);
      rd(OFS_WINDOW, q);
      if (k < 3) begin
        chk("cwp", 32'(2 - k), {30'h0, q[1:0]}); // step down
        getr(5'h1e, q);
        chk("new fp", sp, q); // overlap
        getr(5'h0e, q);
        chk("new sp", sp - {22'h0, sz, 2'h0}, q); // frame
      end else begin
        chk("trap count", 32'(nt + 1), 32'(n_trap)); // trap
        chk("trap num", 32'h1, {26'h0, tnum}); // number
        chk("cwp kept", 32'h0, {30'h0, q[1:0]});
      end
    end
    give_verdict();
  end
endmodule
